//--- pkg/hc_pkg.sv
package hc_pkg;

    // ****************************************************
    // Geometry and register map
    // ****************************************************
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [11:0] CH_STRIDE = 12'h020;
    localparam logic [11:0] FLAGS_OFS = 12'h508;
    localparam logic [11:0] IRQEN_OFS = 12'h50c;
    localparam logic [11:0] XLEN_OFS = 12'h510;

    // ****************************************************
    // Event and enable bit positions
    // ****************************************************
    localparam int EVT_W = 11;
    localparam int BIT_TOGGLE_ERR = 10;
    localparam int BIT_QUEUE_OVR = 9;
    localparam int BIT_BABBLE = 8;
    localparam int BIT_BUS_ERR = 7;
    localparam int BIT_ACK = 5;
    localparam int BIT_NAK = 4;
    localparam int BIT_STALL = 3;
    localparam int BIT_HALTED = 1;
    localparam int BIT_XFER_DONE = 0;
    // Implemented positions; bits 2 and 6 are reserved
    localparam logic [10:0] EVT_MASK = 11'h7bb;

    // ****************************************************
    // Transfer length register fields
    // ****************************************************
    localparam int PID_MSB = 30;
    localparam int PID_LSB = 29;
    localparam int PKT_CNT_MSB = 28;
    localparam int PKT_CNT_LSB = 19;
    localparam int PKT_CNT_W = 10;
    localparam int XFER_LEN_MSB = 18;
    localparam int XFER_LEN_LSB = 0;
    localparam int XFER_LEN_W = 19;
    localparam int PKT_BYTES_W = 11;

    // ****************************************************
    // Reset values
    // ****************************************************
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] IRQEN_RST = 32'h0000_0000;
    localparam logic [31:0] XLEN_RST = 32'h0000_0000;

    // ****************************************************
    // Data PID encoding
    // ****************************************************
    typedef enum logic [1:0] {
        PID_DATA0 = 2'b00,
        PID_RSVD = 2'b01,
        PID_DATA1 = 2'b10,
        PID_SETUP = 2'b11
    } pid_t;

endpackage : hc_pkg

//--- verilog/hc_event_flags.sv
`timescale 1ns/100ps
`default_nettype none
module hc_event_flags
    import hc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Hardware events, one cycle each
    input wire logic [10:0] set_evt,
    // Software access
    input wire logic clr_wr,
    input wire logic en_wr,
    input wire logic [10:0] wdata,
    // State
    output logic [10:0] flags_q,
    output logic [10:0] irq_en_q,
    output logic irq
);

    logic [10:0] flags_ff;
    logic [10:0] en_ff;
    logic [10:0] nxt_flags;
    logic [10:0] clr_mask;

    assign clr_mask = clr_wr ? wdata : 11'h000;
    assign nxt_flags = ((flags_ff & ~clr_mask) | set_evt) & EVT_MASK;

    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_ff <= FLAGS_RST[10:0];
            en_ff <= IRQEN_RST[10:0];
        end else begin
            flags_ff <= nxt_flags;
            if (en_wr) begin
                en_ff <= wdata & EVT_MASK;
            end
        end
    end

    assign flags_q = flags_ff;
    assign irq_en_q = en_ff;
    assign irq = |(flags_ff & en_ff);

endmodule : hc_event_flags
`default_nettype wire

//--- verilog/hc_xfer_tracker.sv
`timescale 1ns/100ps
`default_nettype none
module hc_xfer_tracker
    import hc_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Software write of the length register
    input wire logic sw_wr,
    input wire logic [31:0] sw_wdata,
    // Successful data packet on the bus
    input wire logic pkt_adv,
    // Whole packet moved through a FIFO by software
    input wire logic fifo_dec,
    input wire logic [10:0] fifo_bytes,
    // State
    output logic [31:0] len_q,
    output logic [1:0] pid_q,
    output logic last_pkt
);

    logic [1:0] pid_ff;
    logic [9:0] pkt_cnt_ff;
    logic [18:0] xfer_len_ff;
    logic [1:0] nxt_pid;
    logic [9:0] nxt_pkt_cnt;
    logic [18:0] nxt_xfer_len;
    logic [18:0] dec_bytes;

    always_comb begin
        case (pid_t'(pid_ff))
            PID_DATA0: nxt_pid = PID_DATA1;
            PID_DATA1: nxt_pid = PID_DATA0;
            PID_SETUP: nxt_pid = PID_DATA1;
            default: nxt_pid = pid_ff;
        endcase
    end

    assign nxt_pkt_cnt = (pkt_cnt_ff != 10'h000) ?
        pkt_cnt_ff - 10'h001 : pkt_cnt_ff;
    assign dec_bytes = {8'h00, fifo_bytes};
    assign nxt_xfer_len = (xfer_len_ff > dec_bytes) ?
        xfer_len_ff - dec_bytes : 19'h00000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            pid_ff <= XLEN_RST[PID_MSB:PID_LSB];
            pkt_cnt_ff <= XLEN_RST[PKT_CNT_MSB:PKT_CNT_LSB];
            xfer_len_ff <= XLEN_RST[XFER_LEN_MSB:XFER_LEN_LSB];
        end else if (sw_wr) begin
            pid_ff <= sw_wdata[PID_MSB:PID_LSB];
            pkt_cnt_ff <= sw_wdata[PKT_CNT_MSB:PKT_CNT_LSB];
            xfer_len_ff <= sw_wdata[XFER_LEN_MSB:XFER_LEN_LSB];
        end else begin
            if (pkt_adv) begin
                pid_ff <= nxt_pid;
                pkt_cnt_ff <= nxt_pkt_cnt;
            end
            if (fifo_dec) begin
                xfer_len_ff <= nxt_xfer_len;
            end
        end
    end

    assign len_q = {1'b0, pid_ff, pkt_cnt_ff, xfer_len_ff};
    assign pid_q = pid_ff;
    assign last_pkt = (pkt_cnt_ff == 10'h001);

endmodule : hc_xfer_tracker
`default_nettype wire

//--- verilog/hc_channel_regs.sv
`timescale 1ns/100ps
`default_nettype none
module hc_channel_regs
    import hc_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Data packet results from the link logic
    input wire logic txn_stb,
    input wire logic [2:0] txn_ch,
    input wire logic txn_dir_in,
    input wire logic txn_ok,
    input wire logic [1:0] txn_rx_pid,
    // Other channel events from the link logic
    input wire logic evt_stb,
    input wire logic [2:0] evt_ch,
    input wire logic [10:0] evt_bits,
    // Whole packet moved through a FIFO
    input wire logic fifo_pkt_stb,
    input wire logic [2:0] fifo_ch,
    input wire logic [10:0] fifo_bytes,
    // Per channel state
    output logic [CHANNELS-1:0] ch_irq,
    output logic [2*CHANNELS-1:0] ch_pid
);

    // ****************************************************
    // Per channel wiring
    // ****************************************************
    logic [31:0] flags_word [CHANNELS];
    logic [31:0] irqen_word [CHANNELS];
    logic [31:0] xlen_word [CHANNELS];
    logic [CHANNELS-1:0] sel_flags;
    logic [CHANNELS-1:0] sel_irqen;
    logic [CHANNELS-1:0] sel_xlen;
    logic [CHANNELS-1:0] pkt_adv;
    logic [CHANNELS-1:0] fifo_dec;
    logic [CHANNELS-1:0] last_pkt;
    logic [1:0] cur_pid [CHANNELS];
    logic [10:0] set_evt [CHANNELS];
    logic [31:0] rd_mux;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    genvar i;
    generate
        for (i = 0; i < CHANNELS; i++) begin : g_ch
            logic [11:0] flags_adr;
            logic [11:0] irqen_adr;
            logic [11:0] xlen_adr;
            logic txn_hit;
            logic pid_match;
            logic toggle_err;
            logic in_done;
            logic [10:0] link_evt;
            logic [10:0] flags_q;
            logic [10:0] irq_en_q;

            assign flags_adr = FLAGS_OFS + CH_STRIDE * 12'(i);
            assign irqen_adr = IRQEN_OFS + CH_STRIDE * 12'(i);
            assign xlen_adr = XLEN_OFS + CH_STRIDE * 12'(i);
            assign sel_flags[i] = (reg_addr == flags_adr);
            assign sel_irqen[i] = (reg_addr == irqen_adr);
            assign sel_xlen[i] = (reg_addr == xlen_adr);

            assign txn_hit = txn_stb && (txn_ch == 3'(i));
            assign pid_match = (txn_rx_pid == cur_pid[i]);
            assign toggle_err = txn_hit && txn_dir_in && txn_ok && !pid_match;
            assign pkt_adv[i] = txn_hit && txn_ok &&
                (!txn_dir_in || pid_match);
            assign in_done = pkt_adv[i] && txn_dir_in && last_pkt[i];
            assign fifo_dec[i] = fifo_pkt_stb && (fifo_ch == 3'(i));

            assign link_evt = (evt_stb && (evt_ch == 3'(i))) ?
                evt_bits : 11'h000;
            assign set_evt[i] = link_evt |
                (toggle_err ? 11'(1 << BIT_TOGGLE_ERR) : 11'h000) |
                (in_done ? 11'(1 << BIT_XFER_DONE) : 11'h000);

            hc_event_flags u_flags (
                .mclk(mclk),
                .rst(rst),
                .set_evt(set_evt[i]),
                .clr_wr(reg_wr && sel_flags[i]),
                .en_wr(reg_wr && sel_irqen[i]),
                .wdata(reg_wdata[10:0]),
                .flags_q(flags_q),
                .irq_en_q(irq_en_q),
                .irq(ch_irq[i])
            );

            hc_xfer_tracker u_xfer (
                .mclk(mclk),
                .rst(rst),
                .sw_wr(reg_wr && sel_xlen[i]),
                .sw_wdata(reg_wdata),
                .pkt_adv(pkt_adv[i]),
                .fifo_dec(fifo_dec[i]),
                .fifo_bytes(fifo_bytes),
                .len_q(xlen_word[i]),
                .pid_q(cur_pid[i]),
                .last_pkt(last_pkt[i])
            );

            assign flags_word[i] = {21'h000000, flags_q};
            assign irqen_word[i] = {21'h000000, irq_en_q};
            assign ch_pid[2*i +: 2] = cur_pid[i];
        end
    endgenerate

    // ****************************************************
    // Read path
    // ****************************************************
    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int c = 0; c < CHANNELS; c++) begin
            if (sel_flags[c]) begin
                rd_mux = flags_word[c];
            end
            if (sel_irqen[c]) begin
                rd_mux = irqen_word[c];
            end
            if (sel_xlen[c]) begin
                rd_mux = xlen_word[c];
            end
        end
    end

    // Data stand only in the cycle after the read strobe
    assign nxt_rdata = reg_rd ? rd_mux : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata = rdata_ff;

endmodule : hc_channel_regs
`default_nettype wire

//--- testbench/hc_channel_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module hc_channel_monitor
    import hc_pkg::*;
#(
    parameter int CHANNELS = NUM_CH
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register port
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Link and FIFO events
    input wire logic txn_stb,
    input wire logic [2:0] txn_ch,
    input wire logic txn_dir_in,
    input wire logic txn_ok,
    input wire logic [1:0] txn_rx_pid,
    input wire logic evt_stb,
    input wire logic [2:0] evt_ch,
    input wire logic [10:0] evt_bits,
    input wire logic fifo_pkt_stb,
    input wire logic [2:0] fifo_ch,
    input wire logic [10:0] fifo_bytes,
    // Channel state
    input wire logic [CHANNELS-1:0] ch_irq,
    input wire logic [2*CHANNELS-1:0] ch_pid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Channel 0 packet qualifiers, software length write excluded
    wire logic len_wr = reg_wr && reg_addr == XLEN_OFS;
    wire logic pkt0 = txn_stb && txn_ch == 3'h0 && txn_ok && !len_wr;
    wire logic out0 = pkt0 && !txn_dir_in;
    wire logic in_bad = pkt0 && txn_dir_in && txn_rx_pid != ch_pid[1:0];
    wire logic any_src = evt_stb || txn_stb || reg_wr;

    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero");
    AST_MASK_OFF: assert property (
        reg_wr && reg_addr == IRQEN_OFS && reg_wdata[10:0] == 11'h0
        |=> !ch_irq[0]) else $error("irq with enables clear");
    AST_IRQ_HOLD: assert property (
        !reg_wr && !evt_stb && !txn_stb |=> $stable(ch_irq))
        else $error("irq changed without cause");
    AST_OUT_TOGGLE: assert property (
        out0 && ch_pid[1:0] == 2'b00 |=> ch_pid[1:0] == 2'b10)
        else $error("pid did not toggle");
    AST_SETUP_NEXT: assert property (
        out0 && ch_pid[1:0] == 2'b11 |=> ch_pid[1:0] == 2'b10)
        else $error("setup not followed by data1");
    AST_IN_BAD_HOLD: assert property (in_bad |=> $stable(ch_pid[1:0]))
        else $error("pid moved on mismatch");
    AST_PID_STILL: assert property (
        !txn_stb && !reg_wr |=> $stable(ch_pid))
        else $error("pid moved on its own");
    AST_IRQ_CAUSE: assert property (
        $rose(ch_irq[0]) |-> $past(any_src))
        else $error("irq rose without cause");
    AST_IRQ_W1C: assert property ($fell(ch_irq[0]) |-> $past(reg_wr))
        else $error("irq fell without write");
    cover property (out0);
    cover property (in_bad);
    cover property ($rose(ch_irq[0]));
endmodule : hc_channel_monitor
`default_nettype wire

//--- testbench/usb_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
module usb_dev_model (
    // Clock
    input wire logic mclk,
    // Packet results
    output logic txn_stb,
    output logic [2:0] txn_ch,
    output logic txn_dir_in,
    output logic txn_ok,
    output logic [1:0] txn_rx_pid,
    // Other events
    output logic evt_stb,
    output logic [2:0] evt_ch,
    output logic [10:0] evt_bits
);
    initial begin
        {txn_stb, txn_ch, txn_dir_in, txn_ok, txn_rx_pid} = 8'h0;
        {evt_stb, evt_ch, evt_bits} = 15'h0;
    end
    // Answers after nw + 1 idle cycles; released lines show the inverse
    task automatic pkt(input int nw, input logic [2:0] ch,
                       input logic din, input logic ok, input logic [1:0] p);
        repeat (nw + 1) @(posedge mclk);
        {txn_stb, txn_ch, txn_dir_in, txn_ok, txn_rx_pid} <=
            {1'b1, ch, din, ok, p};
        @(posedge mclk);
        txn_stb <= 1'b0;
        {txn_ch, txn_dir_in, txn_ok, txn_rx_pid} <= ~{ch, din, ok, p};
        #1;
    endtask : pkt
    task automatic evt(input logic [2:0] ch, input logic [10:0] b);
        @(posedge mclk);
        {evt_stb, evt_ch, evt_bits} <= {1'b1, ch, b};
        @(posedge mclk);
        evt_stb <= 1'b0;
        {evt_ch, evt_bits} <= ~{ch, b};
        #1;
    endtask : evt
endmodule : usb_dev_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import hc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic fifo_pkt_stb = 1'b0;
    logic [2:0] fifo_ch = 3'h0;
    logic [10:0] fifo_bytes = 11'h0;
    logic [31:0] reg_rdata;
    logic txn_stb, txn_dir_in, txn_ok, evt_stb;
    logic [2:0] txn_ch, evt_ch;
    logic [1:0] txn_rx_pid;
    logic [10:0] evt_bits;
    logic [7:0] ch_irq;
    logic [15:0] ch_pid;
    int errors = 0;
    int n_compared = 0;
    always #4 mclk = ~mclk;

    hc_channel_regs hc_channel_regs_inst (.mclk(mclk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .txn_stb(txn_stb),
        .txn_ch(txn_ch), .txn_dir_in(txn_dir_in), .txn_ok(txn_ok),
        .txn_rx_pid(txn_rx_pid), .evt_stb(evt_stb), .evt_ch(evt_ch),
        .evt_bits(evt_bits), .fifo_pkt_stb(fifo_pkt_stb),
        .fifo_ch(fifo_ch), .fifo_bytes(fifo_bytes), .ch_irq(ch_irq),
        .ch_pid(ch_pid));
    usb_dev_model usb_dev_model_inst (.mclk(mclk), .txn_stb(txn_stb),
        .txn_ch(txn_ch), .txn_dir_in(txn_dir_in), .txn_ok(txn_ok),
        .txn_rx_pid(txn_rx_pid), .evt_stb(evt_stb), .evt_ch(evt_ch),
        .evt_bits(evt_bits));

    function automatic logic [31:0] lw(input logic [1:0] p,
        input logic [9:0] c, input logic [18:0] b);
        return {1'b0, p, c, b};
    endfunction : lw
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd
    task automatic fifo(input logic [10:0] b);
        @(posedge mclk);
        {fifo_pkt_stb, fifo_ch, fifo_bytes} <= {1'b1, 3'h0, b};
        @(posedge mclk);
        fifo_pkt_stb <= 1'b0;
        {fifo_ch, fifo_bytes} <= ~{3'h0, b};
    endtask : fifo
    task automatic t_regmap();
        rd(12'h5ec, IRQEN_RST);
        rd(12'h5f0, XLEN_RST);
        wr(12'h56c, 32'hffff_ffff);
        rd(12'h56c, 32'h0000_07bb);
        rd(IRQEN_OFS, 32'h0);
        wr(12'h5f0, 32'hffff_ffff);
        rd(12'h5f0, 32'h7fff_ffff);
        chk({16'h0, ch_pid}, {16'h0, PID_SETUP, 14'h0000});
        wr(12'h500, 32'hffff_ffff);
        rd(12'h500, 32'h0);
        $display("regmap done");
    endtask : t_regmap
    task automatic t_irq();
        wr(IRQEN_OFS, 32'h0);
        usb_dev_model_inst.evt(3'h0, 11'h7ff);
        chk({24'h0, ch_irq}, 32'h0);
        rd(FLAGS_OFS, 32'h0000_07bb);
        for (int i = 0; i < EVT_W; i++) begin
            wr(IRQEN_OFS, 32'h1 << i);
            chk({24'h0, ch_irq}, {31'h0, EVT_MASK[i]});
        end
        wr(IRQEN_OFS, 32'h1);
        wr(FLAGS_OFS, 32'h7ff);
        chk({24'h0, ch_irq}, 32'h0);
        rd(IRQEN_OFS, 32'h1);
        $display("irq done");
    endtask : t_irq
    task automatic t_out();
        wr(XLEN_OFS, lw(PID_DATA0, 10'd3, 19'd100));
        usb_dev_model_inst.pkt(3, 3'h0, 1'b0, 1'b1, 2'b00);
        chk({30'h0, ch_pid[1:0]}, {30'h0, PID_DATA1});
        usb_dev_model_inst.pkt(0, 3'h0, 1'b0, 1'b0, 2'b00);
        usb_dev_model_inst.pkt(0, 3'h0, 1'b0, 1'b1, 2'b00);
        fifo(11'd40);
        rd(XLEN_OFS, lw(PID_DATA0, 10'd1, 19'd60));
        $display("out done");
    endtask : t_out
    task automatic t_in();
        wr(FLAGS_OFS, 32'h7ff);
        wr(XLEN_OFS, lw(PID_DATA1, 10'd1, 19'd64));
        wr(IRQEN_OFS, 32'h401);
        usb_dev_model_inst.pkt(2, 3'h0, 1'b1, 1'b1, PID_DATA0);
        rd(FLAGS_OFS, 32'h400);
        chk({24'h0, ch_irq}, 32'h1);
        rd(XLEN_OFS, lw(PID_DATA1, 10'd1, 19'd64));
        usb_dev_model_inst.pkt(0, 3'h0, 1'b1, 1'b1, PID_DATA1);
        rd(FLAGS_OFS, 32'h401);
        fifo(11'd64);
        rd(XLEN_OFS, lw(PID_DATA0, 10'd0, 19'd0));
        $display("in done");
    endtask : t_in
    task automatic t_pid();
        logic [1:0] pin [4] = '{PID_DATA0, PID_DATA1, PID_SETUP, PID_RSVD};
        logic [1:0] pout [4] = '{PID_DATA1, PID_DATA0, PID_DATA1, PID_RSVD};
        for (int k = 0; k < 4; k++) begin
            wr(XLEN_OFS, lw(pin[k], 10'd5, 19'd0));
            usb_dev_model_inst.pkt(k, 3'h0, 1'b0, 1'b1, 2'b00);
            chk({30'h0, ch_pid[1:0]}, {30'h0, pout[k]});
        end
        usb_dev_model_inst.pkt(0, 3'h7, 1'b0, 1'b1, 2'b00);
        chk({16'h0, ch_pid}, {16'h0, PID_DATA1, 12'h000, PID_RSVD});
        $display("pid done");
    endtask : t_pid
    task automatic results();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        t_regmap();
        t_irq();
        t_out();
        t_in();
        t_pid();
        results();
    end
endmodule : tb
bind hc_channel_regs hc_channel_monitor #(.CHANNELS(CHANNELS)) mon_inst (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .txn_stb(txn_stb), .txn_ch(txn_ch), .txn_dir_in(txn_dir_in),
    .txn_ok(txn_ok), .txn_rx_pid(txn_rx_pid), .evt_stb(evt_stb),
    .evt_ch(evt_ch), .evt_bits(evt_bits), .fifo_pkt_stb(fifo_pkt_stb),
    .fifo_ch(fifo_ch), .fifo_bytes(fifo_bytes), .ch_irq(ch_irq),
    .ch_pid(ch_pid));
`default_nettype wire
